/* inc/serial_pkg.sv */
/*
 * Shared constants and types for the two-port serial adapter.
 * Assumes an 8-byte I/O window per port, selected by port number and offset.
 */
package serial_pkg;
    // Geometry
    localparam int PORTS = 2;
    localparam int SUM_W = 8;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int PIN_KINDS = 5;
    localparam int PIN_W = PIN_KINDS * PORTS;

    // Offsets within each port window
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_IIR = 3'h2;
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_SUMMARY = 3'h7;

    // Pin groups in the synchroniser vector, each PORTS wide
    localparam int PIN_RXD = 0;
    localparam int PIN_DCD = 1;
    localparam int PIN_DSR = 2;
    localparam int PIN_CTS = 3;
    localparam int PIN_RI = 4;
    localparam logic [PIN_W-1:0] PIN_RESET = '1;

    // Field positions
    localparam int LCR_DLAB = 7;
    localparam int LCR_EVEN = 4;
    localparam int LCR_PEN = 3;
    localparam int LCR_STOP2 = 2;
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_LS = 2;
    localparam int IER_MS = 3;
    localparam int FCR_EN = 0;
    localparam int FCR_RXCLR = 1;
    localparam int FCR_TXCLR = 2;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;

    // Reset values
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [7:0] LCR_RESET = 8'h03;
    localparam logic [3:0] IER_RESET = 4'h0;
    localparam logic [1:0] MCR_RESET = 2'h0;
    localparam logic [3:0] MS_RESET = 4'hF;

    // Interrupt identification codes, highest priority first
    localparam logic [3:0] IID_LINE = 4'h6;
    localparam logic [3:0] IID_RX = 4'h4;
    localparam logic [3:0] IID_TX = 4'h2;
    localparam logic [3:0] IID_MODEM = 4'h0;
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [1:0] IIR_FIFO_ON = 2'h3;

    // Bit timing: 16 baud ticks per bit
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam logic [2:0] DATA_BITS_BASE = 3'h4;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : serial_pkg

/* logic/byte_fifo.sv */
/*
 * Small synchronous FIFO with valid/ready on both sides and a clear.
 * Assumes DEPTH is a power of two and one clock with a freezing enable.
 */
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clr,
    // Fill side
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    // Drain side
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Honest full and empty flags
    assign wr_ready = cnt_q != FULL;
    assign rd_valid = cnt_q != '0;
    assign rd_data = mem[rp_q];

    // Pointer and count update, clear wins
    always_comb begin
        push = wr_valid && wr_ready;
        pop = rd_valid && rd_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        if (clr) begin
            wp_d = '0;
            rp_d = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (ce && push && !clr) begin
            mem[wp_q] <= wr_data;
        end
    end
endmodule : byte_fifo

/* logic/dual_port_interrupt_status.sv */
/*
 * Two serial ports with shared interrupt line and a pending summary register.
 * Assumes host I/O cycles arrive as one-cycle read/write strobes on clk.
 */
// Behaviour
// - Summary register is eight bits and read-only; writes leave it unchanged.
// - Summary bit is one while its port's interrupt is pending.
// - First port maps to bit 0, second port to bit 1.
// - Summary register decoded at offset 7 in every port window.
// - Every mirrored copy returns the same value.
// - Port interrupts combine onto one host interrupt line.
// - Two independent serial ports share the interrupt and summary scheme.
// - Each port has programmable rate, format, interrupts and 16-byte FIFOs.
// - Ports drive TX, RTS, DTR and sample RX, DCD, DSR, CTS, RI.
`timescale 1ns/1ps
module dual_port_interrupt_status (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Host I/O access
    input wire logic io_port,
    input wire logic [serial_pkg::ADDR_W-1:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [serial_pkg::DATA_W-1:0] io_wdata,
    output logic [serial_pkg::DATA_W-1:0] io_rdata,
    output logic io_rvalid,
    // Shared interrupt
    output logic irq,
    // Serial pins, one bit per port
    output logic [serial_pkg::PORTS-1:0] txd,
    output logic [serial_pkg::PORTS-1:0] rts,
    output logic [serial_pkg::PORTS-1:0] dtr,
    input wire logic [serial_pkg::PORTS-1:0] rxd,
    input wire logic [serial_pkg::PORTS-1:0] dcd,
    input wire logic [serial_pkg::PORTS-1:0] dsr,
    input wire logic [serial_pkg::PORTS-1:0] cts,
    input wire logic [serial_pkg::PORTS-1:0] ri
);
    import serial_pkg::*;

    logic [PIN_W-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    logic [PORTS-1:0] pend_c, pend_q;
    logic irq_q;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic rvalid_q;
    logic [DATA_W-1:0] port_rdata [PORTS];
    logic [SUM_W-1:0] summary;

    // three-stage pin sampling, change taken when stages two and three agree
    always_comb begin
        flt_d = flt_q;
        for (int i = 0; i < PIN_W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                flt_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= PIN_RESET;
            s2_q <= PIN_RESET;
            s3_q <= PIN_RESET;
            flt_q <= PIN_RESET;
        end else if (ce) begin
            s1_q <= {ri, cts, dsr, dcd, rxd};
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end

    // port n drives summary bit n; upper bits zero
    assign summary = {{(SUM_W - PORTS){1'b0}}, pend_q};

    // one identical serial port per generate pass
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        logic [15:0] div_q, div_d, baud_q, baud_d;
        logic [7:0] lcr_q, lcr_d;
        logic [3:0] ier_q, ier_d, msd_q, msd_d, msp_q, ms_now;
        logic [1:0] mcr_q, mcr_d;
        logic fen_q, fen_d;
        logic [2:0] lse_q, lse_d;
        tx_state_t tx_st_q, tx_st_d;
        rx_state_t rx_st_q, rx_st_d;
        logic [3:0] tx_sub_q, tx_sub_d, rx_sub_q, rx_sub_d;
        logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d, data_last;
        logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, rx_char, tx_data, rx_data;
        logic tx_par_q, tx_par_d, rx_par_q, rx_par_d, rx_pe_q, rx_pe_d, txd_q, txd_d;
        logic sel, dlab, tick, tx_pop, rx_pop, rx_push, rx_clr, tx_clr;
        logic tx_valid, tx_ready, rx_valid, rx_ready, temt, rx_f;
        logic [2:0] lse_set;
        logic [3:0] iid;

        byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
            .clk(clk), .rst(rst), .ce(ce), .clr(tx_clr),
            .wr_valid(io_wr && sel && io_addr == ADDR_DATA && !dlab),
            .wr_data(io_wdata), .wr_ready(tx_ready),
            .rd_valid(tx_valid), .rd_data(tx_data), .rd_ready(tx_pop)
        );
        byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
            .clk(clk), .rst(rst), .ce(ce), .clr(rx_clr),
            .wr_valid(rx_push), .wr_data(rx_char), .wr_ready(rx_ready),
            .rd_valid(rx_valid), .rd_data(rx_data), .rd_ready(rx_pop)
        );

        // Decode helpers and filtered pins
        assign sel = io_port == 1'(p);
        assign dlab = lcr_q[LCR_DLAB];
        assign tick = baud_q == '0;
        assign rx_f = flt_q[PIN_RXD * PORTS + p];
        assign ms_now = {flt_q[PIN_DCD * PORTS + p], flt_q[PIN_RI * PORTS + p],
                         flt_q[PIN_DSR * PORTS + p], flt_q[PIN_CTS * PORTS + p]};
        assign data_last = DATA_BITS_BASE + {1'b0, lcr_q[1:0]};
        assign rx_char = rx_sh_q >> (2'h3 - lcr_q[1:0]);
        assign temt = tx_st_q == TX_IDLE && !tx_valid;

        always_comb begin
            if (ier_q[IER_LS] && lse_q != '0) iid = IID_LINE;
            else if (ier_q[IER_RX] && rx_valid) iid = IID_RX;
            else if (ier_q[IER_TX] && !tx_valid) iid = IID_TX;
            else if (ier_q[IER_MS] && msd_q != '0) iid = IID_MODEM;
            else iid = IID_NONE;
        end
        // pending whenever an enabled cause is present
        assign pend_c[p] = iid != IID_NONE;

        // Register read view; offset 7 carries the shared summary
        always_comb begin
            unique case (io_addr)
                ADDR_DATA: port_rdata[p] = dlab ? div_q[7:0] : (rx_valid ? rx_data : 8'h00);
                ADDR_IER: port_rdata[p] = dlab ? div_q[15:8] : {4'h0, ier_q};
                ADDR_IIR: port_rdata[p] = {fen_q ? IIR_FIFO_ON : 2'h0, 2'h0, iid};
                ADDR_LCR: port_rdata[p] = lcr_q;
                ADDR_MCR: port_rdata[p] = {6'h00, mcr_q};
                ADDR_LSR: port_rdata[p] = {1'b0, temt, !tx_valid, 1'b0, lse_q, rx_valid};
                ADDR_MSR: port_rdata[p] = {ms_now, msd_q};
                // summary mirrored in each window; same value everywhere
                ADDR_SUMMARY: port_rdata[p] = summary;
            endcase
        end

        // Host access, baud timing, transmitter and receiver
        always_comb begin
            div_d = div_q; lcr_d = lcr_q; ier_d = ier_q; mcr_d = mcr_q; fen_d = fen_q;
            lse_d = lse_q; msd_d = msd_q; lse_set = '0;
            tx_st_d = tx_st_q; tx_sub_d = tx_sub_q; tx_bit_d = tx_bit_q; tx_sh_d = tx_sh_q;
            tx_par_d = tx_par_q; txd_d = txd_q;
            rx_st_d = rx_st_q; rx_sub_d = rx_sub_q; rx_bit_d = rx_bit_q; rx_sh_d = rx_sh_q;
            rx_par_d = rx_par_q; rx_pe_d = rx_pe_q;
            tx_pop = 1'b0; rx_pop = 1'b0; rx_push = 1'b0; rx_clr = 1'b0; tx_clr = 1'b0;
            baud_d = tick ? div_q - 16'h0001 : baud_q - 16'h0001;
            // writes to the summary offset and status offsets are ignored
            if (io_wr && sel) begin
                unique case (io_addr)
                    ADDR_DATA: if (dlab) div_d[7:0] = io_wdata;
                    ADDR_IER: if (dlab) div_d[15:8] = io_wdata; else ier_d = io_wdata[3:0];
                    ADDR_IIR: begin
                        fen_d = io_wdata[FCR_EN];
                        rx_clr = io_wdata[FCR_RXCLR];
                        tx_clr = io_wdata[FCR_TXCLR];
                    end
                    ADDR_LCR: lcr_d = io_wdata;
                    ADDR_MCR: mcr_d = io_wdata[1:0];
                    ADDR_LSR, ADDR_MSR, ADDR_SUMMARY: ;
                endcase
            end
            // Read side effects
            if (io_rd && sel) begin
                if (io_addr == ADDR_DATA && !dlab) rx_pop = rx_valid;
                if (io_addr == ADDR_LSR) lse_d = '0;
                if (io_addr == ADDR_MSR) msd_d = '0;
            end
            // transmit framing and receive sampling, advanced on each baud tick
            if (tick) begin
                tx_sub_d = tx_sub_q + 4'h1;
                unique case (tx_st_q)
                    TX_IDLE: begin
                        tx_sub_d = '0;
                        txd_d = 1'b1;
                        if (tx_valid) begin
                            tx_pop = 1'b1; tx_sh_d = tx_data; tx_par_d = 1'b0;
                            tx_st_d = TX_START; txd_d = 1'b0;
                        end
                    end
                    TX_START: if (tx_sub_q == SUB_LAST) begin
                        tx_st_d = TX_DATA; tx_bit_d = '0; txd_d = tx_sh_q[0];
                    end
                    TX_DATA: if (tx_sub_q == SUB_LAST) begin
                        tx_par_d = tx_par_q ^ tx_sh_q[0];
                        tx_sh_d = tx_sh_q >> 1;
                        if (tx_bit_q != data_last) begin
                            tx_bit_d = tx_bit_q + 3'h1; txd_d = tx_sh_q[1];
                        end else if (lcr_q[LCR_PEN]) begin
                            tx_st_d = TX_PAR;
                            txd_d = (tx_par_q ^ tx_sh_q[0]) ^ !lcr_q[LCR_EVEN];
                        end else begin
                            tx_st_d = TX_STOP; tx_bit_d = '0; txd_d = 1'b1;
                        end
                    end
                    TX_PAR: if (tx_sub_q == SUB_LAST) begin
                        tx_st_d = TX_STOP; tx_bit_d = '0; txd_d = 1'b1;
                    end
                    TX_STOP: if (tx_sub_q == SUB_LAST) begin
                        if (lcr_q[LCR_STOP2] && tx_bit_q == '0) tx_bit_d = 3'h1;
                        else tx_st_d = TX_IDLE;
                    end
                endcase
                rx_sub_d = rx_sub_q + 4'h1;
                unique case (rx_st_q)
                    RX_IDLE: begin
                        rx_sub_d = '0;
                        if (!rx_f) rx_st_d = RX_START;
                    end
                    RX_START: if (rx_sub_q == SUB_MID) begin
                        rx_sub_d = '0; rx_bit_d = '0; rx_par_d = 1'b0; rx_pe_d = 1'b0;
                        rx_st_d = rx_f ? RX_IDLE : RX_DATA;
                    end
                    RX_DATA: if (rx_sub_q == SUB_LAST) begin
                        rx_sh_d = {rx_f, rx_sh_q[7:1]};
                        rx_par_d = rx_par_q ^ rx_f;
                        rx_bit_d = rx_bit_q + 3'h1;
                        if (rx_bit_q == data_last) rx_st_d = lcr_q[LCR_PEN] ? RX_PAR : RX_STOP;
                    end
                    RX_PAR: if (rx_sub_q == SUB_LAST) begin
                        rx_pe_d = rx_f != (rx_par_q ^ !lcr_q[LCR_EVEN]);
                        rx_st_d = RX_STOP;
                    end
                    RX_STOP: if (rx_sub_q == SUB_LAST) begin
                        rx_push = 1'b1;
                        lse_set = {!rx_f, rx_pe_q, !rx_ready};
                        rx_st_d = RX_IDLE;
                    end
                endcase
            end
            // Sticky status: a new event wins over a clearing read
            lse_d = lse_d | lse_set;
            msd_d = msd_d | {msp_q[3] ^ ms_now[3], msp_q[2] & !ms_now[2],
                             msp_q[1] ^ ms_now[1], msp_q[0] ^ ms_now[0]};
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                div_q <= DIV_RESET; baud_q <= '0; lcr_q <= LCR_RESET; ier_q <= IER_RESET;
                mcr_q <= MCR_RESET; fen_q <= 1'b0; lse_q <= '0; msd_q <= '0; msp_q <= MS_RESET;
                tx_st_q <= TX_IDLE; tx_sub_q <= '0; tx_bit_q <= '0; tx_sh_q <= '0;
                tx_par_q <= 1'b0; txd_q <= 1'b1;
                rx_st_q <= RX_IDLE; rx_sub_q <= '0; rx_bit_q <= '0; rx_sh_q <= '0;
                rx_par_q <= 1'b0; rx_pe_q <= 1'b0;
            end else if (ce) begin
                div_q <= div_d; baud_q <= baud_d; lcr_q <= lcr_d; ier_q <= ier_d;
                mcr_q <= mcr_d; fen_q <= fen_d; lse_q <= lse_d; msd_q <= msd_d; msp_q <= ms_now;
                tx_st_q <= tx_st_d; tx_sub_q <= tx_sub_d; tx_bit_q <= tx_bit_d;
                tx_sh_q <= tx_sh_d; tx_par_q <= tx_par_d; txd_q <= txd_d;
                rx_st_q <= rx_st_d; rx_sub_q <= rx_sub_d; rx_bit_q <= rx_bit_d;
                rx_sh_q <= rx_sh_d; rx_par_q <= rx_par_d; rx_pe_q <= rx_pe_d;
            end
        end

        assign txd[p] = txd_q;
        assign dtr[p] = mcr_q[MCR_DTR];
        assign rts[p] = mcr_q[MCR_RTS];
    end

    // Read data returned one cycle after the strobe
    assign rdata_d = io_rd ? port_rdata[io_port] : rdata_q;

    // pending bits combined onto one interrupt line
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= '0;
            irq_q <= 1'b0;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else if (ce) begin
            pend_q <= pend_c;
            irq_q <= |pend_c;
            rdata_q <= rdata_d;
            rvalid_q <= io_rd;
        end
    end

    assign irq = irq_q;
    assign io_rdata = rdata_q;
    assign io_rvalid = rvalid_q;
endmodule : dual_port_interrupt_status

/* bench/status_asserts.sv */
/*
 * Concurrent checks on host access, shared interrupt and modem pins.
 * Assumes one clock and a synchronous active-high reset on the design.
 */
`timescale 1ns/1ps
module status_asserts (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Host I/O access
    input wire logic io_port,
    input wire logic [serial_pkg::ADDR_W-1:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [serial_pkg::DATA_W-1:0] io_wdata,
    input wire logic [serial_pkg::DATA_W-1:0] io_rdata,
    input wire logic io_rvalid,
    // Interrupt and pins
    input wire logic irq,
    input wire logic [serial_pkg::PORTS-1:0] txd,
    input wire logic [serial_pkg::PORTS-1:0] rts,
    input wire logic [serial_pkg::PORTS-1:0] dtr
);
    import serial_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_read_answered: assert property (io_rd && ce |=> io_rvalid)
        else $error("read strobe not answered");
    a_answer_caused: assert property (io_rvalid |-> $past(io_rd && ce))
        else $error("read answer without read strobe");
    a_write_silent: assert property (io_wr && ce && !io_rd |=> !io_rvalid)
        else $error("write produced a read answer");
    a_rdata_holds: assert property (!io_rvalid && !$past(rst) |-> $stable(io_rdata))
        else $error("read data moved without a read");
    a_upper_bits_zero: assert property (
        io_rd && ce && io_addr == ADDR_SUMMARY |=> io_rdata[7:2] == 6'h00)
        else $error("summary upper bits not zero");
    a_irq_matches_sum: assert property (
        (io_rd && ce && io_addr == ADDR_SUMMARY && $stable(irq)) ##1 $stable(irq)
        |-> irq == (|io_rdata[1:0]))
        else $error("shared interrupt disagrees with summary");
    a_pins_follow_mcr: assert property (
        (io_wr && ce && io_addr == ADDR_MCR && io_port)
        ##1 (ce && !(io_wr && io_addr == ADDR_MCR && io_port))
        |=> rts[1] == $past(io_wdata[MCR_RTS], 2) && dtr[1] == $past(io_wdata[MCR_DTR], 2))
        else $error("modem control pins do not follow register");
    a_reset_idle: assert property ($fell(rst) |->
        txd == 2'h3 && rts == 2'h0 && dtr == 2'h0 && !irq && !io_rvalid)
        else $error("outputs not idle after reset");
endmodule : status_asserts

bind dual_port_interrupt_status status_asserts status_asserts_inst (
    .clk(clk), .rst(rst), .ce(ce), .io_port(io_port), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .irq(irq), .txd(txd), .rts(rts), .dtr(dtr)
);

/* bench/far_end_model.sv */
/*
 * Far-end serial equipment facing both ports.
 * Assumes the bench picks loopback and the clear-to-send level.
 */
`timescale 1ns/1ps
module far_end_model (
    // Controls from the bench
    input wire logic loop_en,
    input wire logic cts_drop,
    // Lines from the ports
    input wire logic [serial_pkg::PORTS-1:0] txd,
    // Lines to the ports
    output logic [serial_pkg::PORTS-1:0] rxd,
    output logic [serial_pkg::PORTS-1:0] dcd,
    output logic [serial_pkg::PORTS-1:0] dsr,
    output logic [serial_pkg::PORTS-1:0] cts,
    output logic [serial_pkg::PORTS-1:0] ri
);
    import serial_pkg::*;

    // receive data, looped or idle mark
    assign rxd = loop_en ? txd : 2'h3;
    assign dcd = 2'h3;
    assign dsr = 2'h3;
    assign ri = 2'h3;
    assign cts = {~cts_drop, 1'b1}; // Only the second port may drop
endmodule : far_end_model

/* bench/testbench.sv */
/*
 * Self-checking bench for the two-port interrupt summary.
 * Assumes the far-end model on the serial pins and a 10 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
    import serial_pkg::*;

    // Design inputs and outputs
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic io_port = 1'b0;
    logic [ADDR_W-1:0] io_addr = 3'h0;
    logic io_rd = 1'b0;
    logic io_wr = 1'b0;
    logic [DATA_W-1:0] io_wdata = 8'h00;
    logic [DATA_W-1:0] io_rdata;
    logic io_rvalid;
    logic irq;
    logic [PORTS-1:0] txd, rts, dtr, rxd, dcd, dsr, cts, ri;
    // Bench state
    logic loop_en = 1'b0;
    logic cts_drop = 1'b0;
    logic [7:0] rd_val;
    logic [3:0] ier_port = 4'b1010;
    logic [7:0] ier_val [4] = '{8'h02, 8'h02, 8'h00, 8'h00};
    logic [7:0] sum_exp [4] = '{8'h01, 8'h03, 8'h02, 8'h00};
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    dual_port_interrupt_status dual_port_interrupt_status_inst (
        .clk(clk), .rst(rst), .ce(ce), .io_port(io_port), .io_addr(io_addr),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .irq(irq), .txd(txd), .rts(rts), .dtr(dtr),
        .rxd(rxd), .dcd(dcd), .dsr(dsr), .cts(cts), .ri(ri)
    );
    far_end_model far_end_model_inst (
        .loop_en(loop_en), .cts_drop(cts_drop), .txd(txd), .rxd(rxd),
        .dcd(dcd), .dsr(dsr), .cts(cts), .ri(ri)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cycles

    // One-cycle write strobe, no answer expected
    task automatic io_write(input logic port, input logic [2:0] addr, input logic [7:0] data);
        @(posedge clk);
        io_wr <= 1'b1;
        io_port <= port;
        io_addr <= addr;
        io_wdata <= data;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask : io_write

    // One-cycle read strobe, answer in the next cycle
    task automatic io_read(input logic port, input logic [2:0] addr, output logic [7:0] data);
        @(posedge clk);
        io_rd <= 1'b1;
        io_port <= port;
        io_addr <= addr;
        @(posedge clk);
        io_rd <= 1'b0;
        #1;
        check("read valid", {7'h00, io_rvalid}, 8'h01);
        data = io_rdata;
    endtask : io_read

    // Summary through both windows, plus the shared line
    task automatic check_sum(input logic [7:0] exp);
        for (int p = 0; p < PORTS; p++) begin
            io_read(p[0], ADDR_SUMMARY, rd_val);
            check("summary", rd_val, exp);
        end
        check("irq", {7'h00, irq}, {7'h00, |exp});
    endtask : check_sum

    // Cycle ceiling against a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        check_sum(8'h00);
        io_write(1'b0, ADDR_SUMMARY, 8'hFF);
        io_write(1'b1, ADDR_SUMMARY, 8'hFF);
        check_sum(8'h00);
        io_write(1'b1, ADDR_MCR, 8'h03);
        io_write(1'b0, ADDR_MCR, 8'h02);
        wait_cycles(3);
        check("rts", {6'h00, rts}, 8'h03);
        check("dtr", {6'h00, dtr}, 8'h02);
        // clock enable low drops a write
        ce <= 1'b0;
        io_write(1'b0, ADDR_MCR, 8'h03);
        ce <= 1'b1;
        wait_cycles(2);
        check("dtr frozen", {6'h00, dtr}, 8'h02);
        for (int i = 0; i < 4; i++) begin
            io_write(ier_port[i], ADDR_IER, ier_val[i]);
            wait_cycles(4);
            check_sum(sum_exp[i]);
        end
        // modem change on the second port
        io_write(1'b1, ADDR_IER, 8'h08);
        cts_drop <= 1'b1;
        wait_cycles(8);
        check_sum(8'h02);
        io_read(1'b1, ADDR_MSR, rd_val);
        check("modem status", rd_val, 8'hE1);
        wait_cycles(3);
        check_sum(8'h00);
        io_write(1'b1, ADDR_IER, 8'h00);
        cts_drop <= 1'b0;
        wait_cycles(8);
        io_read(1'b1, ADDR_MSR, rd_val);
        check("modem status", rd_val, 8'hF1);
        // byte looped through the first port
        loop_en <= 1'b1;
        io_write(1'b0, ADDR_IER, 8'h01);
        io_write(1'b0, ADDR_DATA, 8'hA5);
        for (int i = 0; i < 600 && irq !== 1'b1; i++) begin
            @(posedge clk);
        end
        check_sum(8'h01);
        io_read(1'b0, ADDR_IIR, rd_val);
        check("cause id", rd_val, {4'h0, IID_RX});
        io_read(1'b0, ADDR_DATA, rd_val);
        check("looped byte", rd_val, 8'hA5);
        wait_cycles(3);
        check_sum(8'h00);
        // divisor readback, then seven bits, even parity, two stops on port two
        io_write(1'b1, ADDR_LCR, 8'h80);
        io_write(1'b1, ADDR_DATA, 8'h02);
        io_read(1'b1, ADDR_DATA, rd_val);
        check("divisor low", rd_val, 8'h02);
        io_write(1'b1, ADDR_LCR, 8'h1E);
        io_write(1'b1, ADDR_DATA, 8'h5A);
        wait_cycles(500);
        io_read(1'b1, ADDR_LSR, rd_val);
        check("line status", rd_val, 8'h61);
        io_read(1'b1, ADDR_DATA, rd_val);
        check("looped seven bits", rd_val, 8'h5A);
        // reset in mid-run with a cause pending
        io_write(1'b1, ADDR_IER, 8'h02);
        wait_cycles(3);
        rst <= 1'b1;
        wait_cycles(2);
        rst <= 1'b0;
        wait_cycles(1);
        check("rts after reset", {6'h00, rts}, 8'h00);
        check_sum(8'h00);
        tally_and_finish();
    end
endmodule : testbench
